// file: design/ttp_panel.sv
`timescale 1ns/1ns
// Overview of operation
// RL1: thumbwheel positions 0-3 pick one host line
// RL2: low watched line asserts both selection signals
// RL3: straps force selection, bypassing address compare
// RL4: each momentary press yields one command
// RL5: high-density position drives phase select false
// RL6: low-density position drives phase select low
// RL7: all panel indicators are active low
// RL8: start indicator lit at marker, tape resting
// RL9: write-protect indicator lit without enable ring
// RL10: load-fault indicator lit unless loaded and ready
// RL11: on-line alone does not admit host commands
// RL12: on-line needs switch, select, load, interlocks
// RL13: power-up clears logic; load accepted first
// RL14: before load completes only reset is honoured
// RL15: reset during load aborts it, clears logic
// RL16: once loaded, all commands except load
// RL17: reload only after a vacuum interlock opened
// RL18: loaded tape rewinds from host or panel
// RL19: panel runs off-line, host only on-line
// RL20: inputs synchronised, presses debounced to pulses
// RL21: come up off-line, unloaded, not ready
// RL22: host status driven only while selected-ready-online
// RL23: ready needs interlock, load, unload, rewind high
// RL24: host commands only when selected, ready, on-line
// RL25: at start marker, forward accepted, reverse refused
module ttp_panel
  import ttp_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYCLES_DEF
)
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] unit_sw_in,
  input wire logic [UNIT_LINES-1:0] host_sel_n_in,
  input wire logic strap_sel_in,
  input wire logic strap_sel_aux_in,
  input wire logic load_make_n_in,
  input wire logic load_break_n_in,
  input wire logic online_make_n_in,
  input wire logic online_break_n_in,
  input wire logic unload_make_n_in,
  input wire logic unload_break_n_in,
  input wire logic reset_make_n_in,
  input wire logic reset_break_n_in,
  input wire logic density_sw_in,
  input wire logic tape_start_marker_in,
  input wire logic tape_end_marker_in,
  input wire logic write_ring_in,
  input wire logic delayed_interlock_in,
  input wire logic load_status_n_in,
  input wire logic unload_n_in,
  input wire logic rewind_status_n_in,
  input wire logic vacuum_open_in,
  input wire logic tape_moving_in,
  input wire logic host_forward_cmd_n_in,
  input wire logic host_reverse_cmd_n_in,
  input wire logic host_rewind_cmd_n_in,
  input wire logic host_unload_cmd_n_in,
  output logic unit_selected_out,
  output logic unit_selected_aux_out,
  output logic phase_enc_select_n_out,
  output logic power_on_clear_n_out,
  output logic master_clear_n_out,
  output logic sel_ready_online_out,
  output logic ready_out,
  output logic online_out,
  output logic loaded_out,
  output logic load_cmd_out,
  output logic rewind_cmd_out,
  output logic unload_cmd_out,
  output logic fwd_cmd_out,
  output logic rev_cmd_out,
  output logic start_ind_n_out,
  output logic write_protect_ind_n_out,
  output logic load_fault_ind_n_out,
  output logic online_ind_n_out,
  output logic gcr_ind_n_out,
  output logic pe_ind_n_out,
  output logic host_status_oe_out,
  output logic host_at_start_n_out,
  output logic host_write_protect_n_out,
  output logic host_online_n_out,
  output logic host_ready_n_out,
  output logic host_density_ind_n_out
);

  localparam int PW = $clog2(POR_CYCLES + 1);

  // synchronised copies
  logic [3:0] unit_sw;
  logic [UNIT_LINES-1:0] host_sel_n;
  logic strap_sel, strap_aux;
  logic ld_mk, ld_bk, on_mk, on_bk, un_mk, un_bk, rs_mk, rs_bk;
  logic density, at_start, at_end, ring, delayed_interlock, lds_n, unl_n, rws_n;
  logic vac_open, moving, fwd_n, rev_n, hrew_n, hunl_n;

  logic load_press, online_press, unload_press, reset_press;
  logic hrew_d, hunl_d, hrew_pulse, hunl_pulse;
  logic [PW-1:0] por_cnt;
  logic por_done;
  logic [MCLR_W-1:0] mclr_cnt;
  ttp_state_t state, next_state;
  logic load_take, rewind_take, unload_take;
  logic rearm, unloading, online;
  logic sel_c, aux_c, ready_c, sro_c;

  // selector and straps are static but still pass two flops
  ttp_sync #(.WIDTH(SYNC_W)) u_sync (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .d_in({unit_sw_in, host_sel_n_in, strap_sel_in, strap_sel_aux_in,
           load_make_n_in, load_break_n_in, online_make_n_in, online_break_n_in,
           unload_make_n_in, unload_break_n_in, reset_make_n_in, reset_break_n_in,
           density_sw_in, tape_start_marker_in, tape_end_marker_in, write_ring_in,
           delayed_interlock_in, load_status_n_in, unload_n_in, rewind_status_n_in,
           vacuum_open_in, tape_moving_in, host_forward_cmd_n_in,
           host_reverse_cmd_n_in, host_rewind_cmd_n_in, host_unload_cmd_n_in}),
    .q_out({unit_sw, host_sel_n, strap_sel, strap_aux,
            ld_mk, ld_bk, on_mk, on_bk, un_mk, un_bk, rs_mk, rs_bk,
            density, at_start, at_end, ring, delayed_interlock, lds_n, unl_n, rws_n,
            vac_open, moving, fwd_n, rev_n, hrew_n, hunl_n})
  );

  ttp_button u_load_btn (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .make_n_in(ld_mk),
    .break_n_in(ld_bk),
    .press_out(load_press)
  );

  ttp_button u_online_btn (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .make_n_in(on_mk),
    .break_n_in(on_bk),
    .press_out(online_press)
  );

  ttp_button u_unload_btn (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .make_n_in(un_mk),
    .break_n_in(un_bk),
    .press_out(unload_press)
  );

  ttp_button u_reset_btn (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .make_n_in(rs_mk),
    .break_n_in(rs_bk),
    .press_out(reset_press)
  );

  // spare positions never select, whatever the host drives
  function automatic logic unit_match(input logic [3:0] pos,
                                      input logic [UNIT_LINES-1:0] lines_n);
    unit_match = (pos <= UNIT_MAX) && !lines_n[pos[1:0]]; // RL1 RL2
  endfunction

  assign sel_c = strap_sel | unit_match(unit_sw, host_sel_n); // RL3
  assign aux_c = strap_aux | unit_match(unit_sw, host_sel_n); // RL3
  assign ready_c = (state == ST_LOADED) & delayed_interlock & lds_n & unl_n & rws_n; // RL23 RL21
  assign sro_c = sel_c & ready_c & online; // RL11 RL12
  assign hrew_pulse = hrew_d & ~hrew_n;
  assign hunl_pulse = hunl_d & ~hunl_n;

  // host rewind and unload lines are levels; act on their falling edge
  // reset low like the synchroniser, so no false edge follows reset
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      hrew_d <= 1'b0;
      hunl_d <= 1'b0;
    end
    else
    begin
      hrew_d <= hrew_n;
      hunl_d <= hunl_n;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      por_cnt <= '0;
      por_done <= 1'b0;
    end
    else if (!por_done)
    begin
      if (por_cnt == PW'(POR_CYCLES - 1))
        por_done <= 1'b1;
      else
        por_cnt <= por_cnt + 1'b1;
    end
  end

  // master clear follows power-on clear and every panel reset
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      mclr_cnt <= '0;
    else if (reset_press)
      mclr_cnt <= MCLR_W'(MCLR_CYCLES); // RL15
    else if (mclr_cnt != '0)
      mclr_cnt <= mclr_cnt - 1'b1;
  end

  always_comb
  begin
    next_state = state;
    load_take = 1'b0;
    case (state)
      ST_CLEAR:
        if (por_done)
          next_state = ST_EMPTY; // RL13
      ST_EMPTY:
        if (load_press && !online)
        begin
          next_state = ST_LOADING; // RL13 RL19
          load_take = 1'b1;
        end
      ST_LOADING:
        if (reset_press)
          next_state = ST_EMPTY; // RL15
        else if (delayed_interlock && lds_n)
          next_state = ST_LOADED;
      ST_LOADED:
        if (unloading && vac_open)
          next_state = ST_EMPTY;
        else if (load_press && rearm && !online)
        begin
          next_state = ST_LOADING; // RL16 RL17
          load_take = 1'b1;
        end
      default:
        next_state = ST_CLEAR;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      state <= ST_CLEAR;
    else
      state <= next_state;
  end

  // in the loaded state the load/rewind button means rewind until rearmed
  assign rewind_take = (state == ST_LOADED) && !at_start && // RL18
    ((load_press && !rearm && !online) || (hrew_pulse && sro_c)); // RL19
  assign unload_take = (state == ST_LOADED) &&
    ((unload_press && !online) || (hunl_pulse && sro_c)); // RL19

  // set wins over clear so an opening in the entry cycle is kept
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rearm <= 1'b0;
    else if (state == ST_LOADED && vac_open)
      rearm <= 1'b1; // RL17
    else if (state != ST_LOADED)
      rearm <= 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      unloading <= 1'b0;
    else if (unload_take)
      unloading <= 1'b1;
    else if (state != ST_LOADED)
      unloading <= 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      online <= 1'b0; // RL21
    else if (reset_press || next_state != ST_LOADED)
      online <= 1'b0; // RL14
    else if (online_press)
      online <= ~online;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      load_cmd_out <= 1'b0;
      rewind_cmd_out <= 1'b0;
      unload_cmd_out <= 1'b0;
      fwd_cmd_out <= 1'b0;
      rev_cmd_out <= 1'b0;
    end
    else
    begin
      load_cmd_out <= load_take;
      rewind_cmd_out <= rewind_take;
      unload_cmd_out <= unload_take;
      fwd_cmd_out <= sro_c & ~fwd_n & rev_n; // RL24 RL25
      rev_cmd_out <= sro_c & ~rev_n & fwd_n & ~at_start; // RL24 RL25
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      unit_selected_out <= 1'b0;
      unit_selected_aux_out <= 1'b0;
      phase_enc_select_n_out <= 1'b1;
      power_on_clear_n_out <= 1'b0;
      master_clear_n_out <= 1'b0;
      sel_ready_online_out <= 1'b0;
      ready_out <= 1'b0;
      online_out <= 1'b0;
      loaded_out <= 1'b0;
    end
    else
    begin
      unit_selected_out <= sel_c; // RL2
      unit_selected_aux_out <= aux_c; // RL2
      phase_enc_select_n_out <= density; // RL5 RL6
      power_on_clear_n_out <= por_done; // RL13
      master_clear_n_out <= por_done && mclr_cnt == '0 && !reset_press; // RL13
      sel_ready_online_out <= sro_c; // RL12
      ready_out <= ready_c; // RL23
      online_out <= online;
      loaded_out <= state == ST_LOADED;
    end
  end

  // indicators stay dark until power-on clear has finished
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      start_ind_n_out <= 1'b1;
      write_protect_ind_n_out <= 1'b1;
      load_fault_ind_n_out <= 1'b1;
      online_ind_n_out <= 1'b1;
      gcr_ind_n_out <= 1'b1;
      pe_ind_n_out <= 1'b1;
    end
    else
    begin
      start_ind_n_out <= ~(por_done & at_start & ~moving); // RL7 RL8
      write_protect_ind_n_out <= ~(por_done & ~ring); // RL7 RL9
      load_fault_ind_n_out <= ~(por_done & ~ready_c); // RL10 RL21
      online_ind_n_out <= ~(por_done & online); // RL11
      gcr_ind_n_out <= ~(por_done & density); // RL5
      pe_ind_n_out <= ~(por_done & ~density); // RL6
    end
  end

  // undriven status lines idle high, as an open collector would
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      host_status_oe_out <= 1'b0;
      host_at_start_n_out <= 1'b1;
      host_write_protect_n_out <= 1'b1;
      host_online_n_out <= 1'b1;
      host_ready_n_out <= 1'b1;
      host_density_ind_n_out <= 1'b1;
    end
    else
    begin
      host_status_oe_out <= sro_c; // RL22
      host_at_start_n_out <= ~(sro_c & at_start); // RL22
      host_write_protect_n_out <= ~(sro_c & ~ring); // RL22
      host_online_n_out <= ~(sro_c & online); // RL22
      host_ready_n_out <= ~sro_c; // RL22
      host_density_ind_n_out <= ~(sro_c & ~density); // RL22
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  unit_spare_a: assert property (
    (unit_sw > UNIT_MAX && !strap_sel) |=> !unit_selected_out) // RL1
    else $error("spare thumbwheel position selected the unit");

  strap_select_a: assert property (
    strap_sel && strap_aux |=> unit_selected_out && unit_selected_aux_out) // RL3
    else $error("strap did not force selection");

  density_map_a: assert property (
    $stable(density) [*2] |-> phase_enc_select_n_out == density) // RL5
    else $error("phase select does not follow density selector");

  not_loaded_a: assert property (
    state != ST_LOADED |=> !online_out && !rewind_cmd_out && !unload_cmd_out) // RL14
    else $error("command honoured before load completed");

  reset_abort_a: assert property (
    state == ST_LOADING && reset_press |=> state == ST_EMPTY ##1 !master_clear_n_out) // RL15
    else $error("reset did not abort the load");

  reload_gate_a: assert property (
    state == ST_LOADED && !rearm |=> !load_cmd_out) // RL17
    else $error("reload accepted without vacuum opening");

  host_gate_a: assert property (
    !sel_ready_online_out |-> !fwd_cmd_out && !rev_cmd_out && !host_status_oe_out) // RL24
    else $error("host lines active outside selected-ready-online");

  start_reverse_a: assert property (rev_cmd_out |-> !$past(at_start)) // RL25
    else $error("reverse accepted at start marker");

  ready_cause_a: assert property (
    ready_out |-> $past(delayed_interlock) && $past(lds_n) && $past(unl_n) && $past(rws_n)) // RL23
    else $error("ready without all its conditions");

endmodule

// file: design/ttp_pkg.sv
package ttp_pkg;

  // system clock rate
  localparam int CLK_MHZ = 250;

  // contact bounce window for panel pushbuttons
  localparam int DEBOUNCE_US = 4;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

  // power-on clear hold time
  localparam int POR_US = 100;
  localparam int POR_CYCLES_DEF = POR_US * CLK_MHZ;

  // master clear pulse after a panel reset
  localparam int MCLR_NS = 400;
  localparam int MCLR_CYCLES = (MCLR_NS * CLK_MHZ) / 1000;
  localparam int MCLR_W = 8;

  // thumbwheel: only positions 0..3 address a host line
  localparam int UNIT_LINES = 4;
  localparam logic [3:0] UNIT_MAX = 4'h3;

  // raw inputs passed through the synchroniser
  localparam int SYNC_W = 32;

  typedef enum logic [3:0] {
    ST_CLEAR   = 4'h1,
    ST_EMPTY   = 4'h2,
    ST_LOADING = 4'h4,
    ST_LOADED  = 4'h8
  } ttp_state_t;

endpackage

// file: design/ttp_sync.sv
`timescale 1ns/1ns
module ttp_sync
  import ttp_pkg::*;
#(
  parameter int WIDTH = SYNC_W
)
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  // first stage feeds the second stage only
  logic [WIDTH-1:0] meta;

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      meta <= '0;
      q_out <= '0;
    end
    else
    begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule

// file: design/ttp_button.sv
`timescale 1ns/1ns
module ttp_button
  import ttp_pkg::*;
#(
  parameter int BOUNCE_CYCLES = DEBOUNCE_CYCLES
)
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic make_n_in,
  input wire logic break_n_in,
  output logic press_out
);

  localparam int CW = $clog2(BOUNCE_CYCLES + 1);

  logic held;
  logic [CW-1:0] cnt;
  logic want_press;
  logic want_release;

  // both contacts must agree; mid-travel states are ignored
  assign want_press = ~make_n_in & break_n_in;
  assign want_release = make_n_in & ~break_n_in;

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cnt <= '0;
      held <= 1'b0;
      press_out <= 1'b0;
    end
    else
    begin
      press_out <= 1'b0;
      if ((want_press & ~held) | (want_release & held))
      begin
        if (cnt == CW'(BOUNCE_CYCLES - 1))
        begin
          cnt <= '0;
          held <= ~held;
          press_out <= ~held; // RL4 RL20
        end
        else
        begin
          cnt <= cnt + 1'b1;
        end
      end
      else
      begin
        cnt <= '0;
      end
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  press_single_a: assert property (press_out |=> !press_out) // RL20
    else $error("press pulse lasted more than one cycle");

  press_needs_hold_a: assert property (
    press_out |-> $past(want_press) && $past(want_press, 2)) // RL4
    else $error("press pulse without a held contact");

endmodule

// file: test/ttp_host_model.sv
`timescale 1ns/1ns
module ttp_host_model
  import ttp_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic [1:0] unit_addr_in,
  input wire logic select_in,
  input wire logic fwd_in,
  input wire logic rev_in,
  input wire logic rewind_in,
  input wire logic unload_in,
  output logic [UNIT_LINES-1:0] host_sel_n_out = '1,
  output logic host_forward_cmd_n_out = 1'b1,
  output logic host_reverse_cmd_n_out = 1'b1,
  output logic host_rewind_cmd_n_out = 1'b1,
  output logic host_unload_cmd_n_out = 1'b1
);
  // address lines not driven sit at the bus pull-up level
  always @(posedge core_clk_in)
  begin
    host_sel_n_out <= select_in ? ~(4'h1 << unit_addr_in) : 4'hf;
    host_forward_cmd_n_out <= ~fwd_in;
    host_reverse_cmd_n_out <= ~rev_in;
    host_rewind_cmd_n_out <= ~rewind_in;
    host_unload_cmd_n_out <= ~unload_in;
  end
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import ttp_pkg::*;
  logic clk, nrst, strap, strap_aux, density, start_m, end_m, ring, dint, lds_n, unl_n, rws_n;
  logic vac, moving, h_sel, h_fwd, h_rev, h_rew, h_unl;
  logic [3:0] unit_sw, mk_n, bk_n, sel_n;
  logic [1:0] h_addr;
  logic f_n, r_n, rw_n, ul_n;
  logic sel_o, sel_aux_o, pe_n_o, poc_n_o, mclr_n_o, sro_o, ready_o, online_o, loaded_o;
  logic load_o, rew_o, fwd_o, rev_o, st_ind, wp_ind, lf_ind, onl_ind, gcr_ind, pe_ind;
  logic oe_o, h_onl_n, h_rdy_n, unl_o, h_st_n, h_wp_n, h_dd_n;
  int bad_count, num_checks, n_load, n_rew, n_mclr, e_load, e_rew, n_unl;
  localparam int LOAD = 0;
  localparam int ONL = 1;
  localparam int RST = 3;

  ttp_host_model host_u (.core_clk_in(clk), .unit_addr_in(h_addr), .select_in(h_sel),
    .fwd_in(h_fwd), .rev_in(h_rev), .rewind_in(h_rew), .unload_in(h_unl),
    .host_sel_n_out(sel_n), .host_forward_cmd_n_out(f_n), .host_reverse_cmd_n_out(r_n),
    .host_rewind_cmd_n_out(rw_n), .host_unload_cmd_n_out(ul_n));

  ttp_panel #(.POR_CYCLES(20)) dut_u (.core_clk_in(clk), .nrst_in(nrst), .unit_sw_in(unit_sw),
    .host_sel_n_in(sel_n), .strap_sel_in(strap), .strap_sel_aux_in(strap_aux),
    .load_make_n_in(mk_n[0]), .load_break_n_in(bk_n[0]), .online_make_n_in(mk_n[1]),
    .online_break_n_in(bk_n[1]), .unload_make_n_in(mk_n[2]), .unload_break_n_in(bk_n[2]),
    .reset_make_n_in(mk_n[3]), .reset_break_n_in(bk_n[3]), .density_sw_in(density),
    .tape_start_marker_in(start_m), .tape_end_marker_in(end_m), .write_ring_in(ring),
    .delayed_interlock_in(dint), .load_status_n_in(lds_n), .unload_n_in(unl_n),
    .rewind_status_n_in(rws_n), .vacuum_open_in(vac), .tape_moving_in(moving),
    .host_forward_cmd_n_in(f_n), .host_reverse_cmd_n_in(r_n), .host_rewind_cmd_n_in(rw_n),
    .host_unload_cmd_n_in(ul_n), .unit_selected_out(sel_o), .unit_selected_aux_out(sel_aux_o),
    .phase_enc_select_n_out(pe_n_o), .power_on_clear_n_out(poc_n_o),
    .master_clear_n_out(mclr_n_o), .sel_ready_online_out(sro_o), .ready_out(ready_o),
    .online_out(online_o), .loaded_out(loaded_o), .load_cmd_out(load_o),
    .rewind_cmd_out(rew_o), .unload_cmd_out(unl_o), .fwd_cmd_out(fwd_o), .rev_cmd_out(rev_o),
    .start_ind_n_out(st_ind), .write_protect_ind_n_out(wp_ind), .load_fault_ind_n_out(lf_ind),
    .online_ind_n_out(onl_ind), .gcr_ind_n_out(gcr_ind), .pe_ind_n_out(pe_ind),
    .host_status_oe_out(oe_o), .host_at_start_n_out(h_st_n), .host_write_protect_n_out(h_wp_n),
    .host_online_n_out(h_onl_n), .host_ready_n_out(h_rdy_n), .host_density_ind_n_out(h_dd_n));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // command pulses last one cycle and master clear is counted per low cycle, so all are tallied on every edge
  always @(posedge clk)
  begin
    if (load_o === 1'b1)
      n_load++;
    if (rew_o === 1'b1)
      n_rew++;
    if (unl_o === 1'b1)
      n_unl++;
    if (mclr_n_o === 1'b0)
      n_mclr++;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", what, exp, seen);
    end
  endtask

  // release must stay stable a full bounce window before the next press
  task automatic press(input int b);
    mk_n[b] = 1'b0;
    bk_n[b] = 1'b1;
    step(DEBOUNCE_CYCLES + 10);
    mk_n[b] = 1'b1;
    bk_n[b] = 1'b0;
    step(DEBOUNCE_CYCLES + 10);
  endtask

  task automatic pulses(input string what);
    chk({what, " load pulses"}, n_load == e_load, 1'b1);
    chk({what, " rewind pulses"}, n_rew == e_rew, 1'b1);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #300000;
    bad_count++;
    tally_and_finish;
  end

  initial
  begin
    {nrst, strap, strap_aux, density, start_m, end_m, ring, dint, lds_n, vac, moving} = '0;
    {h_sel, h_fwd, h_rev, h_rew, h_unl, h_addr} = '0;
    {unl_n, rws_n} = 2'b11;
    unit_sw = 4'h0;
    mk_n = 4'hf;
    bk_n = 4'h0;
    {bad_count, num_checks, n_load, n_rew, e_load, e_rew, n_unl} = '0;
    step(8);
    nrst = 1'b1;
    step(2);
    chk("power_on_clear_n", poc_n_o, 1'b0);
    step(30);
    chk("power_on_clear_n", poc_n_o, 1'b1);
    chk("online", online_o, 1'b0);
    chk("load_fault_ind_n", lf_ind, 1'b0);
    $display("test power_up done");

    for (int u = 0; u < 4; u++)
    begin
      unit_sw = 4'(u);
      h_addr = 2'(u);
      h_sel = 1'b1;
      step(6);
      chk("unit_selected", sel_o, 1'b1);
      chk("unit_selected_aux", sel_aux_o, 1'b1);
      h_addr = 2'(u + 1);
      step(6);
      chk("unit_selected", sel_o, 1'b0);
    end
    unit_sw = 4'h5;
    step(6);
    chk("spare_position", sel_o, 1'b0);
    h_sel = 1'b0;
    strap = 1'b1;
    step(6);
    chk("strap_selected", sel_o, 1'b1);
    chk("strap_aux_only", sel_aux_o, 1'b0);
    strap_aux = 1'b1;
    step(6);
    chk("strap_both_sel", sel_o, 1'b1);
    chk("strap_aux_selected", sel_aux_o, 1'b1);
    strap = 1'b0;
    step(6);
    chk("strap_aux_sel_only", sel_o, 1'b0);
    chk("strap_aux_alone", sel_aux_o, 1'b1);
    strap_aux = 1'b0;
    $display("test selection done");

    density = 1'b1;
    step(6);
    chk("phase_enc_select_n", pe_n_o, 1'b1);
    chk("gcr_ind_n", gcr_ind, 1'b0);
    density = 1'b0;
    step(6);
    chk("phase_enc_select_n", pe_n_o, 1'b0);
    chk("pe_ind_n", pe_ind, 1'b0);
    chk("write_protect_ind_n", wp_ind, 1'b0);
    ring = 1'b1;
    step(6);
    chk("write_protect_ind_n", wp_ind, 1'b1);
    $display("test density done");

    press(ONL);
    chk("online_before_load", online_o, 1'b0);
    press(LOAD);
    e_load++;
    pulses("first load");
    n_mclr = 0;
    press(RST);
    chk("master_clear_len", n_mclr >= MCLR_CYCLES && n_mclr <= MCLR_CYCLES + 2, 1'b1);
    chk("loaded_after_abort", loaded_o, 1'b0);
    press(LOAD);
    e_load++;
    pulses("load after abort");
    {dint, lds_n} = 2'b11;
    step(8);
    chk("loaded", loaded_o, 1'b1);
    chk("ready", ready_o, 1'b1);
    chk("load_fault_ind_n", lf_ind, 1'b1);
    rws_n = 1'b0;
    step(6);
    chk("ready_while_rewinding", ready_o, 1'b0);
    chk("load_fault_ind_n", lf_ind, 1'b0);
    rws_n = 1'b1;
    start_m = 1'b1;
    step(6);
    chk("start_ind_n", st_ind, 1'b0);
    moving = 1'b1;
    step(6);
    chk("start_ind_n_moving", st_ind, 1'b1);
    moving = 1'b0;
    $display("test load done");

    press(LOAD);
    pulses("load at start marker");
    start_m = 1'b0;
    press(LOAD);
    e_rew++;
    pulses("panel rewind");
    vac = 1'b1;
    step(10);
    vac = 1'b0;
    press(LOAD);
    e_load++;
    pulses("reload after vacuum");
    step(8);
    $display("test reload done");

    press(ONL);
    chk("online", online_o, 1'b1);
    chk("online_ind_n", onl_ind, 1'b0);
    chk("sro_unselected", sro_o, 1'b0);
    chk("status_oe_unselected", oe_o, 1'b0);
    unit_sw = 4'h2;
    h_addr = 2'h2;
    h_sel = 1'b1;
    h_fwd = 1'b1;
    step(6);
    chk("sel_ready_online", sro_o, 1'b1);
    chk("status_oe", oe_o, 1'b1);
    chk("host_ready_n", h_rdy_n, 1'b0);
    chk("host_online_n", h_onl_n, 1'b0);
    chk("fwd_cmd", fwd_o, 1'b1);
    h_fwd = 1'b0;
    h_rev = 1'b1;
    start_m = 1'b1;
    ring = 1'b0;
    step(6);
    chk("rev_at_start", rev_o, 1'b0);
    chk("host_at_start_n", h_st_n, 1'b0);
    chk("host_write_protect_n", h_wp_n, 1'b0);
    chk("host_density_ind_n", h_dd_n, 1'b0);
    start_m = 1'b0;
    step(6);
    chk("rev_cmd", rev_o, 1'b1);
    h_rev = 1'b0;
    h_rew = 1'b1;
    step(5);
    h_rew = 1'b0;
    step(6);
    e_rew++;
    pulses("host rewind");
    h_unl = 1'b1;
    step(5);
    h_unl = 1'b0;
    step(6);
    chk("host unload pulses", n_unl == 1, 1'b1);
    press(LOAD);
    pulses("panel while online");
    h_fwd = 1'b1;
    h_sel = 1'b0;
    step(6);
    chk("status_oe_deselected", oe_o, 1'b0);
    chk("fwd_deselected", fwd_o, 1'b0);
    vac = 1'b1;
    step(8);
    chk("online_after_unload", online_o, 1'b0);
    chk("loaded_after_unload", loaded_o, 1'b0);
    chk("load_fault_after_unload", lf_ind, 1'b0);
    chk("unload pulses total", n_unl == 1, 1'b1);
    $display("test online done");
    tally_and_finish;
  end
endmodule
